// file: design/hdcr_pkg.sv
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package hdcr_pkg;

    //--------------------------------------------------------------------------
    // Register map
    //--------------------------------------------------------------------------
    localparam logic [7:0]  CTRL_ADDR      = 8'h1d;
    localparam logic [7:0]  CTRL_RESET     = 8'ha0;
    localparam int          NG_HI_BIT      = 7;
    localparam int          NG_LO_BIT      = 6;
    localparam int          ROT_OL_BIT     = 5;
    localparam int          COMP_OFF_BIT   = 4;
    localparam int          RT_UNS_BIT     = 3;
    localparam int          UPD_RATE_BIT   = 2;
    localparam int          ANALOG_BIT     = 1;
    localparam int          RES_OL_BIT     = 0;

    //--------------------------------------------------------------------------
    // Noise gate and level arithmetic
    //--------------------------------------------------------------------------
    localparam logic [15:0] NG_PCT_LOW     = 16'h0002;
    localparam logic [15:0] NG_PCT_MID     = 16'h0004;
    localparam logic [15:0] NG_PCT_HIGH    = 16'h0008;
    localparam logic [15:0] PCT_SCALE      = 16'h0064;
    localparam logic [15:0] FULL_SCALE     = 16'h00ff;
    localparam logic [7:0]  SUPPLY_NOMINAL = 8'h80;
    localparam logic [2:0]  MODE_PIN_INPUT = 3'h3;

    //--------------------------------------------------------------------------
    // Commutation divider: toggle every 64 edges gives a divide by 128
    //--------------------------------------------------------------------------
    localparam logic [5:0]  COMM_HALF_LAST = 6'h3f;

    typedef enum logic [1:0] {
        HDCR_PH_FIRST  = 2'b01,
        HDCR_PH_SECOND = 2'b10
    } hdcr_phase_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [7:0]  gated;
        logic [7:0]  rt_mag;
        logic        rt_rev;
        logic [7:0]  comp;
        logic        comp_rev;
        logic [7:0]  drive;
        logic        drive_rev;
        logic        update;
        hdcr_phase_t phase;
        logic        rot_ol;
        logic        res_ol;
        logic        analog;
        logic        div_en;
    } hdcr_state_t;

    localparam hdcr_state_t STATE_RESET = '{
        ctrl: CTRL_RESET, rdata: 8'h00, rvalid: 1'b0, gated: 8'h00,
        rt_mag: 8'h00, rt_rev: 1'b0, comp: 8'h00, comp_rev: 1'b0,
        drive: 8'h00, drive_rev: 1'b0, update: 1'b0, phase: HDCR_PH_FIRST,
        rot_ol: 1'b1, res_ol: 1'b0, analog: 1'b0, div_en: 1'b0};

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [5:0] cnt;
        logic       comm;
    } hdcr_div_state_t;

    localparam hdcr_div_state_t DIV_RESET = '{
        sync1: 1'b0, sync2: 1'b0, prev: 1'b0, cnt: 6'h00, comm: 1'b0};

endpackage : hdcr_pkg

// file: design/hdcr_commutation_div.sv
`timescale 1ns/10ps
module hdcr_commutation_div
    import hdcr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic enable_i,
    input  wire logic pin_i,
    output logic      commutation_o
);

    hdcr_div_state_t q;
    hdcr_div_state_t d;
    logic            rise;

    always_comb begin
        d       = q;
        d.sync1 = pin_i;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;
        rise    = q.sync2 & ~q.prev;
        if (!enable_i) begin
            d.cnt  = 6'h00;
            d.comm = 1'b0;
        end else if (rise) begin
            if (q.cnt == COMM_HALF_LAST) begin
                d.cnt  = 6'h00;
                d.comm = ~q.comm;
            end else begin
                d.cnt = q.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            q <= DIV_RESET;
        end else begin
            q <= d;
        end
    end

    assign commutation_o = q.comm;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    comm_toggle_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $changed(q.comm) && $past(enable_i) |-> $past(q.cnt) == COMM_HALF_LAST && $past(rise))
        else $error("Commutation toggled before 64 input edges.");

    comm_count_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        enable_i && rise && q.cnt != COMM_HALF_LAST |=> q.cnt == $past(q.cnt) + 6'h01 && $stable(q.comm))
        else $error("Commutation edge count did not advance.");

endmodule : hdcr_commutation_div

// file: design/hdcr_drive_config.sv
`timescale 1ns/10ps
module hdcr_drive_config
    import hdcr_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_RD_I,
    input  wire logic [2:0] MODE_I,
    input  wire logic       LINEAR_RESONANT_I,
    input  wire logic       REALTIME_PLAYBACK_I,
    input  wire logic [7:0] REALTIME_DATA_I,
    input  wire logic [7:0] INPUT_LEVEL_I,
    input  wire logic [7:0] SUPPLY_LEVEL_I,
    input  wire logic       HALF_CYCLE_I,
    input  wire logic       INPUT_TRIGGER_PIN_I,
    output logic [7:0]      REG_RDATA_O,
    output logic            REG_RVALID_O,
    output logic [7:0]      GATED_LEVEL_O,
    output logic [7:0]      DRIVE_LEVEL_O,
    output logic            DRIVE_REVERSE_O,
    output logic            AMP_UPDATE_O,
    output logic            ROTATING_MASS_OPEN_LOOP_SEL_O,
    output logic            RESONANT_OPEN_LOOP_SEL_O,
    output logic            ANALOG_INPUT_SEL_O,
    output logic            COMMUTATION_O
);

    hdcr_state_t q;
    hdcr_state_t d;
    logic        reg_hit;
    logic        pin_mode;
    logic        do_update;
    logic [7:0]  src_mag;
    logic        src_rev;
    logic [7:0]  rt_neg;

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    function automatic logic [7:0] noise_gate(input logic [7:0] lvl, input logic [1:0] sel);
        logic [15:0] pct;
        pct = PCT_SCALE;
        case (sel)
            2'h1:    pct = NG_PCT_LOW;
            2'h2:    pct = NG_PCT_MID;
            2'h3:    pct = NG_PCT_HIGH;
            default: pct = 16'h0000;
        endcase
        // Level is a fraction of 255, so compare in percent without a divider.
        if ({8'h00, lvl} * PCT_SCALE < pct * FULL_SCALE) begin
            return 8'h00;
        end
        return lvl;
    endfunction : noise_gate

    function automatic logic [7:0] supply_scale(input logic [7:0] lvl, input logic [7:0] sup);
        logic [15:0] prod;
        logic [15:0] quo;
        prod = {8'h00, lvl} * {8'h00, SUPPLY_NOMINAL};
        quo  = 16'hffff;
        if (sup != 8'h00) begin
            quo = prod / {8'h00, sup};
        end
        // A sagging supply asks for more than full scale; clip instead of wrapping.
        if (quo > FULL_SCALE) begin
            return 8'hff;
        end
        return quo[7:0];
    endfunction : supply_scale

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------
    always_comb begin
        d         = q;
        reg_hit   = (REG_ADDR_I == CTRL_ADDR);
        pin_mode  = (MODE_I == MODE_PIN_INPUT);
        src_mag   = q.gated;
        src_rev   = 1'b0;
        do_update = 1'b1;
        rt_neg    = 8'h00 - REALTIME_DATA_I;

        if (REG_WR_I && reg_hit) begin
            d.ctrl = REG_WDATA_I;
        end
        d.rvalid = REG_RD_I;
        d.rdata  = (REG_RD_I && reg_hit) ? q.ctrl : 8'h00;

        d.gated = noise_gate(INPUT_LEVEL_I, q.ctrl[NG_HI_BIT:NG_LO_BIT]);

        if (q.ctrl[RT_UNS_BIT]) begin
            d.rt_mag = REALTIME_DATA_I;
            d.rt_rev = 1'b0;
        end else if (REALTIME_DATA_I[7]) begin
            d.rt_mag = (REALTIME_DATA_I == 8'h80) ? 8'hff : {rt_neg[6:0], 1'b0};
            d.rt_rev = 1'b1;
        end else begin
            d.rt_mag = {REALTIME_DATA_I[6:0], REALTIME_DATA_I[6]};
            d.rt_rev = 1'b0;
        end

        if (REALTIME_PLAYBACK_I) begin
            src_mag = q.rt_mag;
            src_rev = q.rt_rev;
        end
        d.comp     = q.ctrl[COMP_OFF_BIT] ? src_mag : supply_scale(src_mag, SUPPLY_LEVEL_I);
        d.comp_rev = src_rev;

        // Resonant drive only changes amplitude at half-cycle boundaries.
        if (LINEAR_RESONANT_I) begin
            do_update = 1'b0;
            if (HALF_CYCLE_I) begin
                case (q.phase)
                    HDCR_PH_FIRST: begin
                        d.phase   = HDCR_PH_SECOND;
                        do_update = q.ctrl[UPD_RATE_BIT];
                    end
                    HDCR_PH_SECOND: begin
                        d.phase   = HDCR_PH_FIRST;
                        do_update = 1'b1;
                    end
                    default: begin
                        d.phase   = HDCR_PH_FIRST;
                        do_update = 1'b0;
                    end
                endcase
            end
        end else begin
            d.phase = HDCR_PH_FIRST;
        end
        d.update = do_update;
        if (do_update) begin
            d.drive     = q.comp;
            d.drive_rev = q.comp_rev;
        end

        d.rot_ol = q.ctrl[ROT_OL_BIT];
        d.analog = pin_mode & q.ctrl[ANALOG_BIT];
        // Open loop has no meaning on an analog level, so tracking stays on then.
        d.res_ol = q.ctrl[RES_OL_BIT] & ~d.analog;
        d.div_en = q.ctrl[RES_OL_BIT] & pin_mode & ~q.ctrl[ANALOG_BIT] & LINEAR_RESONANT_I;
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    hdcr_commutation_div hdcr_commutation_div_inst (
        .clk_i         (CLK_I),
        .reset_n_i     (RESET_N_I),
        .enable_i      (q.div_en),
        .pin_i         (INPUT_TRIGGER_PIN_I),
        .commutation_o (COMMUTATION_O)
    );

    assign REG_RDATA_O                   = q.rdata;
    assign REG_RVALID_O                  = q.rvalid;
    assign GATED_LEVEL_O                 = q.gated;
    assign DRIVE_LEVEL_O                 = q.drive;
    assign DRIVE_REVERSE_O               = q.drive_rev;
    assign AMP_UPDATE_O                  = q.update;
    assign ROTATING_MASS_OPEN_LOOP_SEL_O = q.rot_ol;
    assign RESONANT_OPEN_LOOP_SEL_O      = q.res_ol;
    assign ANALOG_INPUT_SEL_O            = q.analog;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    reset_value_a: assert property ($rose(RESET_N_I) |-> q.ctrl == CTRL_RESET)
        else $error("Control register missed its reset value.");

    write_read_a: assert property (
        REG_WR_I && reg_hit ##1 !REG_WR_I ##1 REG_RD_I && reg_hit && !REG_WR_I |=>
        REG_RDATA_O == $past(REG_WDATA_I, 3))
        else $error("Read did not return the last written value.");

    gate_off_a: assert property (
        q.ctrl[NG_HI_BIT:NG_LO_BIT] == 2'h0 |=> GATED_LEVEL_O == $past(INPUT_LEVEL_I))
        else $error("Disabled noise gate altered the level.");

    gate_high_a: assert property (
        q.ctrl[NG_HI_BIT:NG_LO_BIT] == 2'h3 |=>
        GATED_LEVEL_O == (($past(INPUT_LEVEL_I) <= 8'h14) ? 8'h00 : $past(INPUT_LEVEL_I)))
        else $error("Eight percent noise gate threshold wrong.");

    rot_loop_a: assert property (##1 ROTATING_MASS_OPEN_LOOP_SEL_O == $past(q.ctrl[ROT_OL_BIT]))
        else $error("Rotating-mass loop select does not follow bit 5.");

    comp_off_a: assert property (
        q.ctrl[COMP_OFF_BIT] && !REALTIME_PLAYBACK_I |=> q.comp == $past(q.gated))
        else $error("Compensation applied while turned off.");

    comp_on_a: assert property (
        !q.ctrl[COMP_OFF_BIT] && SUPPLY_LEVEL_I == SUPPLY_NOMINAL && !REALTIME_PLAYBACK_I |=> q.comp == $past(q.gated))
        else $error("Compensation changed level at nominal supply.");

    rt_format_a: assert property (
        q.ctrl[RT_UNS_BIT] |=> q.rt_mag == $past(REALTIME_DATA_I) && !q.rt_rev)
        else $error("Unsigned playback data was reinterpreted.");

    once_rate_a: assert property (
        LINEAR_RESONANT_I && !q.ctrl[UPD_RATE_BIT] && HALF_CYCLE_I && q.phase == HDCR_PH_FIRST |=> !AMP_UPDATE_O)
        else $error("Amplitude updated mid-cycle at once-per-cycle rate.");

    twice_rate_a: assert property (
        LINEAR_RESONANT_I && q.ctrl[UPD_RATE_BIT] && HALF_CYCLE_I |=> AMP_UPDATE_O && DRIVE_LEVEL_O == $past(q.comp))
        else $error("Half-cycle update missing at twice-per-cycle rate.");

    analog_sel_a: assert property (##1 ANALOG_INPUT_SEL_O == $past(pin_mode & q.ctrl[ANALOG_BIT]))
        else $error("Input type select wrong.");

    open_loop_a: assert property (
        ##1 RESONANT_OPEN_LOOP_SEL_O == $past(q.ctrl[RES_OL_BIT] & ~(pin_mode & q.ctrl[ANALOG_BIT])))
        else $error("Resonant open loop select wrong.");

endmodule : hdcr_drive_config

// file: sim/hdcr_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module hdcr_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic [7:0]      addr_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o,
    output logic            rd_o
);
    initial begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        wdata_o = 8'h00;
        rd_o    = 1'b0;
    end

    // Data is inverted after the strobe drops, so a late capture shows up as a wrong value.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        d = 8'hxx;
        for (n = 0; n < 4; n++) begin
            @(posedge clk_i);
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                break;
            end
        end
    endtask : read_reg
endmodule : hdcr_host_model

// file: sim/hdcr_drive_config_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module hdcr_drive_config_tb_top
    import hdcr_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n;
    logic [7:0] addr, wdata, rdata, rtdata, lvl, sup, gated, drive;
    logic       wr, rd, rvalid, lin, rt_play, half, pin, rev, upd, rot_ol, res_ol, ana, comm;
    logic [2:0] mode;
    logic       comm_q = 1'b0;
    int         errors = 0;
    int         n_compared = 0;
    int         upd_cnt = 0;
    int         comm_cnt = 0;
    int         c0;
    logic [7:0] pat [4] = '{8'h55, 8'haa, 8'hff, 8'h00};
    logic [7:0] th  [4] = '{8'h05, 8'h05, 8'h0a, 8'h14};

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (upd === 1'b1) upd_cnt <= upd_cnt + 1;
        comm_q <= comm;
        if (comm !== comm_q) comm_cnt <= comm_cnt + 1;
    end

    hdcr_host_model hdcr_host_model_inst (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
        .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

    hdcr_drive_config hdcr_drive_config_inst (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .MODE_I(mode), .LINEAR_RESONANT_I(lin),
        .REALTIME_PLAYBACK_I(rt_play), .REALTIME_DATA_I(rtdata), .INPUT_LEVEL_I(lvl), .SUPPLY_LEVEL_I(sup),
        .HALF_CYCLE_I(half), .INPUT_TRIGGER_PIN_I(pin), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .GATED_LEVEL_O(gated), .DRIVE_LEVEL_O(drive), .DRIVE_REVERSE_O(rev), .AMP_UPDATE_O(upd),
        .ROTATING_MASS_OPEN_LOOP_SEL_O(rot_ol), .RESONANT_OPEN_LOOP_SEL_O(res_ol),
        .ANALOG_INPUT_SEL_O(ana), .COMMUTATION_O(comm));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] d);
        hdcr_host_model_inst.write_reg(CTRL_ADDR, d);
    endtask : wreg

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        hdcr_host_model_inst.read_reg(a, d);
        chk(d, exp);
    endtask : rdchk

    task automatic selchk(input logic [2:0] m, input logic [7:0] v, input logic a, input logic l);
        mode <= m;
        wreg(v);
        tick(2);
        chk({7'h0, ana}, {7'h0, a});
        chk({7'h0, res_ol}, {7'h0, l});
    endtask : selchk

    task automatic rtchk(input logic [7:0] fmt, input logic [7:0] v, input logic [7:0] d, input logic r);
        wreg(fmt);
        rtdata <= v;
        tick(6);
        chk(drive, d);
        chk({7'h0, rev}, {7'h0, r});
    endtask : rtchk

    task automatic halves(input logic [7:0] v, input logic [7:0] exp);
        wreg(v);
        tick(4);
        c0 = upd_cnt;
        repeat (4) begin
            half <= 1'b1;
            tick(1);
            half <= 1'b0;
            tick(3);
        end
        tick(3);
        chk(8'(upd_cnt - c0), exp);
    endtask : halves

    task automatic tally_and_finish;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        rst_n  = 1'b0;
        mode   = 3'h0;
        lin    = 1'b0;
        rt_play = 1'b0;
        rtdata = 8'h00;
        lvl    = 8'h00;
        sup    = 8'h80;
        half   = 1'b0;
        pin    = 1'b0;
        tick(2);
        rst_n <= 1'b1;
        rdchk(CTRL_ADDR, 8'ha0);
        chk({7'h0, rot_ol}, 8'h01);
        foreach (pat[i]) begin
            wreg(pat[i]);
            rdchk(CTRL_ADDR, pat[i]);
            chk({7'h0, rot_ol}, {7'h0, pat[i][5]});
            chk({7'h0, res_ol}, {7'h0, pat[i][0]});
        end
        hdcr_host_model_inst.write_reg(8'h1e, 8'hff);
        rdchk(CTRL_ADDR, 8'h00);
        rdchk(8'h1e, 8'h00);
        selchk(3'h3, 8'h03, 1'b1, 1'b0);
        selchk(3'h3, 8'h01, 1'b0, 1'b1);
        selchk(3'h2, 8'h03, 1'b0, 1'b1);
        mode <= 3'h0;
        for (int g = 0; g < 4; g++) begin
            wreg({g[1:0], 6'h10});
            lvl <= th[g];
            tick(3);
            chk(gated, (g == 0) ? th[g] : 8'h00);
            lvl <= th[g] + 8'h01;
            tick(3);
            chk(gated, th[g] + 8'h01);
        end
        // Rotating mass reloads every cycle, so a few cycles cover the whole pipe.
        wreg(8'h00);
        lvl <= 8'h40;
        sup <= 8'h40;
        tick(6);
        chk(drive, 8'h80);
        sup <= 8'h20;
        tick(6);
        chk(drive, 8'hff);
        wreg(8'h10);
        tick(6);
        chk(drive, 8'h40);
        sup <= 8'h80;
        rt_play <= 1'b1;
        rtchk(8'h08, 8'h90, 8'h90, 1'b0);
        rtchk(8'h00, 8'h30, 8'h60, 1'b0);
        rtchk(8'h00, 8'h80, 8'hff, 1'b1);
        rtchk(8'h00, 8'hf0, 8'h20, 1'b1);
        rt_play <= 1'b0;
        lin <= 1'b1;
        halves(8'h10, 8'h02);
        halves(8'h14, 8'h04);
        mode <= 3'h3;
        wreg(8'h11);
        tick(4);
        c0 = comm_cnt;
        repeat (192) begin
            pin <= 1'b1;
            tick(4);
            pin <= 1'b0;
            tick(4);
        end
        tick(8);
        chk(8'(comm_cnt - c0), 8'h03);
        wreg(8'h13);
        tick(4);
        chk({7'h0, comm}, 8'h00);
        tally_and_finish();
    end
endmodule : hdcr_drive_config_tb_top
